// >>> rtl/sat_count_if.sv
// Link between the top level and one saturating counter
`timescale 1ns/100ps

interface sat_count_if #(parameter int WIDTH = 12);
  logic inc;
  logic latch;
  logic [WIDTH-1:0] held;

  modport counter (input inc, input latch, output held);
  modport user (output inc, output latch, input held);
endinterface

// >>> rtl/sat_counter.sv
// Saturating event counter with a latched copy taken at each boundary
`timescale 1ns/100ps

module sat_counter #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Count control and latched value
  sat_count_if.counter cif
);

  typedef struct packed {
    logic [WIDTH-1:0] run_q;
    logic [WIDTH-1:0] held_q;
  } cnt_state_s;

  localparam logic [WIDTH-1:0] MAX_COUNT = '1;

  cnt_state_s st_q;
  cnt_state_s st_d;
  logic [WIDTH-1:0] run_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: saturate, then latch and restart on a boundary
  always_comb begin
    st_d = st_q;
    run_next = st_q.run_q;
    if (cif.inc && st_q.run_q != MAX_COUNT) begin
      run_next = st_q.run_q + 1'b1;
    end
    if (cif.latch) begin
      st_d.held_q = run_next;
      st_d.run_q = '0;
    end else begin
      st_d.run_q = run_next;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.held = st_q.held_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_count_saturates: assert property (
    st_q.run_q == MAX_COUNT && !cif.latch |=> st_q.run_q == MAX_COUNT)
    else $error("Counter left its maximum inside an interval");

  a_count_steps: assert property (
    !cif.latch && cif.inc && st_q.run_q != MAX_COUNT
    |=> st_q.run_q == $past(st_q.run_q) + 1'b1)
    else $error("Counter missed an event");

  a_latch_restart: assert property (
    cif.latch |=> st_q.run_q == '0 &&
    st_q.held_q >= $past(st_q.run_q))
    else $error("Boundary did not latch and restart");

  a_held_steady: assert property (
    !cif.latch |=> $stable(st_q.held_q))
    else $error("Latched value moved between boundaries");

  c_count_saturated: cover property (st_q.run_q == MAX_COUNT);

endmodule

// >>> rtl/t1_path_error_counters.sv
// Path and out-of-sync error counters of one T1 receive framer
//
// Function
// - ESF: path counter is 12 bits and counts CRC6 code-word errors.
// - D4: count terminal framing errors, plus signaling ones if enabled.
// - ESF ignores the signaling-framing enable; only CRC6 errors count.
// - Path counter holds still while sync is lost, in any mode.
// - Path count: top bits in 0x25 bits 3..0, low byte at 0x26.
// - Byte 0x25 shared: upper nibble out-of-sync, lower nibble path.
// - Select set: count multiframes out of sync, only while sync lost.
// - Select clear: count D4 terminal or ESF pattern errors; off when lost.
// - Out-of-sync count: top bits 0x25 bits 7..4, low byte at 0x27.
// - Both counters latch and restart each second or each 42 ms.
// - Counters saturate at maximum and never wrap inside an interval.
`timescale 1ns/100ps
`include "t1_path_error_params.svh"

module t1_path_error_counters #(
  parameter int COUNT_WIDTH = `COUNT_WIDTH,
  parameter int ONE_SECOND_CYCLES = `ONE_SECOND_CYCLES,
  parameter int FAST_INTERVAL_CYCLES = `FAST_INTERVAL_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Framing configuration levels
  input wire logic framing_mode_select,
  input wire logic fs_error_count_enable,
  input wire logic oos_count_select,
  input wire logic update_interval_select,
  // Receive synchronizer events and status
  input wire logic crc6_error,
  input wire logic terminal_framing_bit_error,
  input wire logic signaling_framing_bit_error,
  input wire logic esf_framing_pattern_error,
  input wire logic multiframe_tick,
  input wire logic sync_lost_flag,
  // Register read port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interval boundary
  output logic update_strobe
);

  t1_path_error_pkg::top_state_s st_q;
  t1_path_error_pkg::top_state_s st_d;
  t1_path_error_pkg::timer_t limit;
  logic boundary;
  logic esf_mode;

  sat_count_if #(.WIDTH(COUNT_WIDTH)) path_if ();
  sat_count_if #(.WIDTH(COUNT_WIDTH)) oos_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer: one second or the short interval
  assign limit = update_interval_select
    ? t1_path_error_pkg::timer_t'(FAST_INTERVAL_CYCLES - 1)
    : t1_path_error_pkg::timer_t'(ONE_SECOND_CYCLES - 1);
  assign boundary = (st_q.timer_q >= limit);
  assign update_strobe = boundary;
  assign esf_mode = framing_mode_select;

  ////////////////////////////////////////////////////////////////////////////
  // Event selection for the two counters
  always_comb begin
    // Path counter: CRC6 in ESF, framing bits in D4, off when sync lost
    if (esf_mode) begin
      path_if.inc = crc6_error && !sync_lost_flag;
    end else begin
      path_if.inc = (terminal_framing_bit_error ||
        (fs_error_count_enable && signaling_framing_bit_error))
        && !sync_lost_flag;
    end
    // Second counter: multiframes out of sync, or framing pattern errors
    if (oos_count_select) begin
      oos_if.inc = multiframe_tick && sync_lost_flag;
    end else if (esf_mode) begin
      oos_if.inc = esf_framing_pattern_error && !sync_lost_flag;
    end else begin
      oos_if.inc = terminal_framing_bit_error && !sync_lost_flag;
    end
    path_if.latch = boundary;
    oos_if.latch = boundary;
  end

  // The two counters
  sat_counter #(.WIDTH(COUNT_WIDTH)) u_path_counter (
    .core_clk(core_clk),
    .resetn(resetn),
    .cif(path_if.counter)
  );

  sat_counter #(.WIDTH(COUNT_WIDTH)) u_oos_counter (
    .core_clk(core_clk),
    .resetn(resetn),
    .cif(oos_if.counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: timer and registered read data
  always_comb begin
    st_d = st_q;
    if (boundary) begin
      st_d.timer_q = `TIMER_RESET;
    end else begin
      st_d.timer_q = st_q.timer_q + 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `PATH_OOS_HIGH_OFFSET: begin
          st_d.rdata_q = {oos_if.held[11:8],
            path_if.held[11:8]};
        end
        `PATH_COUNT_LOW_OFFSET: begin
          st_d.rdata_q = path_if.held[7:0];
        end
        `OOS_COUNT_LOW_OFFSET: begin
          st_d.rdata_q = oos_if.held[7:0];
        end
        default: begin
          st_d.rdata_q = `RDATA_RESET;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q.timer_q <= `TIMER_RESET;
      st_q.rdata_q <= `RDATA_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_path_esf_crc: assert property (
    esf_mode && crc6_error && !sync_lost_flag |-> path_if.inc)
    else $error("CRC6 error not counted in ESF");

  a_path_esf_only: assert property (
    esf_mode && !crc6_error |-> !path_if.inc)
    else $error("Path counter counted a non-CRC event in ESF");

  a_path_d4_fs: assert property (
    !esf_mode && signaling_framing_bit_error && !sync_lost_flag
    |-> path_if.inc == (fs_error_count_enable || terminal_framing_bit_error))
    else $error("Signaling framing error handled wrongly in D4");

  a_path_lost_off: assert property (
    sync_lost_flag |-> !path_if.inc)
    else $error("Path counter ran while sync lost");

  a_oos_mf_count: assert property (
    oos_count_select && multiframe_tick |-> oos_if.inc == sync_lost_flag)
    else $error("Out-of-sync multiframe miscounted");

  a_oos_fbit_lost: assert property (
    !oos_count_select && sync_lost_flag |-> !oos_if.inc)
    else $error("Framing pattern counter ran while sync lost");

  a_shared_byte: assert property (
    reg_rd && reg_addr == `PATH_OOS_HIGH_OFFSET
    |=> reg_rdata == {$past(oos_if.held[11:8]), $past(path_if.held[11:8])})
    else $error("Shared high byte read wrong");

  a_path_low_read: assert property (
    reg_rd && reg_addr == `PATH_COUNT_LOW_OFFSET
    |=> reg_rdata == $past(path_if.held[7:0]))
    else $error("Path low byte read wrong");

  a_oos_low_read: assert property (
    reg_rd && reg_addr == `OOS_COUNT_LOW_OFFSET
    |=> reg_rdata == $past(oos_if.held[7:0]))
    else $error("Out-of-sync low byte read wrong");

  a_boundary_period: assert property (
    boundary |=> st_q.timer_q == `TIMER_RESET && !boundary)
    else $error("Interval timer did not restart");

  a_read_no_effect: assert property (
    reg_rd && !boundary |=> $stable(path_if.held) && $stable(oos_if.held))
    else $error("Read disturbed latched counts");

  a_path_d4_ft: assert property (
    !esf_mode && terminal_framing_bit_error && !sync_lost_flag
    |-> path_if.inc)
    else $error("Terminal framing error not counted in D4");

  a_oos_fbit_pick: assert property (
    !oos_count_select && !sync_lost_flag
    |-> oos_if.inc == (esf_mode ? esf_framing_pattern_error :
    terminal_framing_bit_error))
    else $error("Framing pattern error miscounted");

  a_oos_mf_only: assert property (
    oos_count_select && !multiframe_tick |-> !oos_if.inc)
    else $error("Out-of-sync counter took a non-multiframe event");

  a_unmapped_zero: assert property (
    reg_rd && reg_addr != `PATH_OOS_HIGH_OFFSET &&
    reg_addr != `PATH_COUNT_LOW_OFFSET && reg_addr != `OOS_COUNT_LOW_OFFSET
    |=> reg_rdata == `RDATA_RESET)
    else $error("Unmapped read returned data");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read");

  c_boundary: cover property (boundary);
  c_d4_fs: cover property (
    !esf_mode && fs_error_count_enable && signaling_framing_bit_error &&
    path_if.inc);
  c_esf_crc: cover property (esf_mode && path_if.inc);
  c_oos_mf: cover property (oos_count_select && oos_if.inc);

endmodule

// >>> rtl/t1_path_error_params.svh
// Offsets, field positions, reset values and timing counts of the counters
`ifndef T1_PATH_ERROR_PARAMS_SVH
`define T1_PATH_ERROR_PARAMS_SVH

// Register offsets on the parallel port
`define PATH_OOS_HIGH_OFFSET 8'h25
`define PATH_COUNT_LOW_OFFSET 8'h26
`define OOS_COUNT_LOW_OFFSET 8'h27

// Counter layout
`define COUNT_WIDTH 12
`define COUNT_RESET 12'h000
`define PATH_HIGH_LSB 0
`define OOS_HIGH_LSB 4
`define RDATA_RESET 8'h00

// Update interval timing
`define CLOCK_HZ 20000000
`define ONE_SECOND_MS 1000
`define FAST_INTERVAL_MS 42
`define ONE_SECOND_CYCLES (`ONE_SECOND_MS * (`CLOCK_HZ / 1000))
`define FAST_INTERVAL_CYCLES (`FAST_INTERVAL_MS * (`CLOCK_HZ / 1000))
`define TIMER_WIDTH 25
`define TIMER_RESET 25'h0000000

`endif

// >>> rtl/t1_path_error_pkg.sv
// Types shared by the path and out-of-sync counters
`include "t1_path_error_params.svh"

package t1_path_error_pkg;

  typedef logic [`COUNT_WIDTH-1:0] count_t;
  typedef logic [`TIMER_WIDTH-1:0] timer_t;

  // State of the top level
  typedef struct packed {
    timer_t timer_q;
    logic [7:0] rdata_q;
  } top_state_s;

endpackage

// >>> verification/t1_path_error_counters_tb_top.sv
// Self-checking bench for the path and out-of-sync error counters
`timescale 1ns/100ps

module t1_path_error_counters_tb_top;
  localparam int ONE_CYC = 5000;
  localparam int FAST_CYC = 40;

  logic core_clk, resetn;
  logic framing_mode_select, fs_error_count_enable;
  logic oos_count_select, update_interval_select;
  logic crc6_error, terminal_framing_bit_error;
  logic signaling_framing_bit_error, esf_framing_pattern_error;
  logic multiframe_tick, sync_lost_flag;
  logic [7:0] reg_addr, reg_rdata;
  logic reg_rd, update_strobe;
  int bad_count, num_checks, seed, bcnt, cyc_cnt;
  logic [11:0] path_run, oos_run, path_lat, oos_lat;
  logic skip, sat, pend;
  logic [7:0] pexp;
  logic [7:0] addrs [6] = '{8'h25, 8'h26, 8'h27, 8'h25, 8'h28, 8'hff};

  ////////////////////////////////////////////////////////////////////////////
  // Device under test with short intervals
  t1_path_error_counters #(
    .ONE_SECOND_CYCLES(ONE_CYC),
    .FAST_INTERVAL_CYCLES(FAST_CYC)
  ) u_t1_path_error_counters (
    .core_clk(core_clk), .resetn(resetn),
    .framing_mode_select(framing_mode_select),
    .fs_error_count_enable(fs_error_count_enable),
    .oos_count_select(oos_count_select),
    .update_interval_select(update_interval_select),
    .crc6_error(crc6_error),
    .terminal_framing_bit_error(terminal_framing_bit_error),
    .signaling_framing_bit_error(signaling_framing_bit_error),
    .esf_framing_pattern_error(esf_framing_pattern_error),
    .multiframe_tick(multiframe_tick), .sync_lost_flag(sync_lost_flag),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .update_strobe(update_strobe)
  );

  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, expectation functions and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Path counter gating by mode and sync state
  function automatic logic path_inc();
    if (sync_lost_flag) return 1'b0;
    if (framing_mode_select) return crc6_error;
    return terminal_framing_bit_error |
           (fs_error_count_enable & signaling_framing_bit_error);
  endfunction

  // Second counter gating by select, mode and sync state
  function automatic logic oos_inc();
    if (oos_count_select) return multiframe_tick & sync_lost_flag;
    if (sync_lost_flag) return 1'b0;
    return framing_mode_select ? esf_framing_pattern_error :
           terminal_framing_bit_error;
  endfunction

  function automatic logic [7:0] reg_exp(input logic [7:0] a);
    case (a)
      8'h25: return {oos_lat[11:8], path_lat[11:8]};
      8'h26: return path_lat[7:0];
      8'h27: return oos_lat[7:0];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [11:0] sat_add(input logic [11:0] v,
                                          input logic i);
    return (v == 12'hfff) ? v : v + {11'h0, i};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of running counts, latches and interval length
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      path_run = 12'h000; oos_run = 12'h000;
      path_lat = 12'h000; oos_lat = 12'h000;
      cyc_cnt = 0;
    end else begin
      path_run = sat_add(path_run, path_inc());
      oos_run = sat_add(oos_run, oos_inc());
      if (update_strobe === 1'b1) begin
        if (!skip) begin
          chk(cyc_cnt + 1,
            update_interval_select ? FAST_CYC : ONE_CYC);
        end
        path_lat = path_run; oos_lat = oos_run;
        path_run = 12'h000; oos_run = 12'h000;
        cyc_cnt = 0; skip = 1'b0; bcnt++;
      end else cyc_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One cycle of stimulus with an optional read
  task automatic step(input logic rd, input logic [7:0] a);
    logic [31:0] r;
    @(negedge core_clk);
    if (pend) chk({4'h0, reg_rdata}, {4'h0, pexp});
    pend = rd; pexp = reg_exp(a);
    reg_rd = rd; reg_addr = a;
    r = $random(seed);
    crc6_error = sat | r[0];
    terminal_framing_bit_error = ~sat & r[1];
    signaling_framing_bit_error = ~sat & r[2];
    esf_framing_pattern_error = ~sat & r[3];
    multiframe_tick = ~sat & r[4];
    if (!sat && r[7:5] == 3'h0) sync_lost_flag = ~sync_lost_flag;
  endtask

  task automatic wait_strobe;
    int n0;
    n0 = bcnt;
    for (int i = 0; i < 6000 && bcnt == n0; i++) step(1'b0, 8'h00);
    if (bcnt == n0) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: saturation over a long interval, then mode sweep
  initial begin
    seed = 92971; bad_count = 0; num_checks = 0; bcnt = 0;
    resetn = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    framing_mode_select = 1'b1; fs_error_count_enable = 1'b0;
    oos_count_select = 1'b0; update_interval_select = 1'b0;
    crc6_error = 1'b0; terminal_framing_bit_error = 1'b0;
    signaling_framing_bit_error = 1'b0; esf_framing_pattern_error = 1'b0;
    multiframe_tick = 1'b0; sync_lost_flag = 1'b0;
    skip = 1'b0; sat = 1'b1; pend = 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    wait_strobe();
    foreach (addrs[k]) step(1'b1, addrs[k]);
    sat = 1'b0; skip = 1'b1;
    update_interval_select = 1'b1;
    for (int i = 0; i < 40; i++) begin
      wait_strobe();
      {framing_mode_select, fs_error_count_enable, oos_count_select} =
        i[2:0];
      foreach (addrs[k]) step(1'b1, addrs[k]);
    end
    step(1'b0, 8'h00);
    // Mid-run reset: read data and latched counts return to zero
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(update_strobe, 1'b0);
    resetn = 1'b1;
    chk(reg_rdata, 8'h00);
    foreach (addrs[k]) step(1'b1, addrs[k]);
    wait_strobe();
    step(1'b0, 8'h00);
    report_and_stop();
  end
endmodule
